// file: core/lpd_map.svh
// Purpose: constants of the loop pulse dialler sequencer
// Assumes: 250 MHz system clock, 18 kHz dialler time base
// Notes: times in their own unit, tick counts derived from them
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

// ****************************************
// register map
// ****************************************
`define LPD_ADDR_CTRL 8'h00
`define LPD_ADDR_STAT 8'h04
`define LPD_CTRL_RATIO_LSB 0
`define LPD_CTRL_GAP_LSB 2
`define LPD_CTRL_MODE_LSB 4
`define LPD_CTRL_CLR_BIT 6
`define LPD_CTRL_RST 6'h00
`define LPD_STAT_WR_LSB 6
`define LPD_STAT_RD_LSB 11
`define LPD_SYNC_RST 18'h00fff

// ****************************************
// timing
// ****************************************
`define LPD_SYS_HZ 250000000
`define LPD_TICK_HZ 18000
`define LPD_TICK_DIV ((`LPD_SYS_HZ + `LPD_TICK_HZ / 2) / `LPD_TICK_HZ)
`define LPD_TK_MS(ms) ((((ms) * `LPD_TICK_HZ) + 999) / 1000)
`define LPD_PULSE_MS 100
`define LPD_GAP_A_MS 700
`define LPD_GAP_B_MS 800
`define LPD_GAP_C_MS 900
`define LPD_GAP_TEST_TENTH_MS 133
`define LPD_TEST_PPS 600
`define LPD_DEB_MS 8
`define LPD_SCAN_MS 5
`define LPD_PULSE_TK `LPD_TK_MS(`LPD_PULSE_MS)
`define LPD_TEST_PULSE_TK (`LPD_TICK_HZ / `LPD_TEST_PPS)
`define LPD_GAP_TEST_TK (((`LPD_GAP_TEST_TENTH_MS * `LPD_TICK_HZ) + 9999) / 10000)
`define LPD_DEB_TK `LPD_TK_MS(`LPD_DEB_MS)
`define LPD_COL_TK (`LPD_TK_MS(`LPD_SCAN_MS) / 3)
`define LPD_RATIO_DEN 30
`define LPD_BRK_NUM_70 21
`define LPD_BRK_NUM_67 20
`define LPD_BRK_NUM_60 18
`define LPD_BRK_NUM_50 15
`endif

// file: core/lpd_pkg.sv
// Purpose: types of the loop pulse dialler sequencer
// Assumes: nothing beyond the map header
// Notes: codes 1..10 digits, 11 access pause, 12 redial/release
package lpd_pkg;
  typedef enum logic [2:0] {
    LPD_IDLE = 3'h0,
    LPD_PRE = 3'h1,
    LPD_BRK = 3'h3,
    LPD_MAK = 3'h2,
    LPD_GAP = 3'h6,
    LPD_HOLD = 3'h7
  } lpd_state_t;
  typedef enum logic [1:0] {
    LPD_M_SINGLE = 2'h0,
    LPD_M_TWO7 = 2'h1,
    LPD_M_BIN = 2'h2,
    LPD_M_MATRIX = 2'h3
  } lpd_kmode_t;
  typedef logic [3:0] lpd_code_t;
endpackage

// file: core/lpd_keyin.sv
// Purpose: key capture, anti-bounce and code decode
// Assumes: inputs already synchronised, tick at the dialler rate
// Notes: emits one pulse per accepted key, invalid codes dropped
`timescale 1ns/100ps
`include "lpd_map.svh"
module lpd_keyin import lpd_pkg::*; #(
  parameter int DEB_TK = `LPD_DEB_TK,
  parameter int COL_TK = `LPD_COL_TK
) (
  input logic clk,
  input logic srst_n,
  input logic tick,
  input lpd_kmode_t mode,
  input logic [11:0] keypad_n,
  input logic [3:0] key_input_line,
  input logic key_common,
  output logic [2:0] scan_n_ff,
  output logic acc_ff,
  output lpd_code_t code_ff
);
  // key index to code: 1..9, star, 0, hash
  function automatic lpd_code_t key_code(input logic [3:0] idx);
    if (idx < 4'h9) return lpd_code_t'(idx + 4'h1);
    else if (idx == 4'h9) return 4'hb;
    else if (idx == 4'ha) return 4'ha;
    else return 4'hc;
  endfunction
  // lowest set bit index of a four-bit row vector
  function automatic logic [1:0] row_of(input logic [3:0] v);
    if (v[0]) return 2'h0;
    else if (v[1]) return 2'h1;
    else if (v[2]) return 2'h2;
    else return 2'h3;
  endfunction
  // two-out-of-seven table, bits read in input order 1..4
  function automatic lpd_code_t dec_two7(input logic [3:0] k);
    logic [3:0] v;
    v = {k[0], k[1], k[2], k[3]};
    case (v)
      4'h0: return 4'h1;
      4'h1: return 4'h2;
      4'h2: return 4'h3;
      4'h4: return 4'h4;
      4'h5: return 4'h5;
      4'h6: return 4'h6;
      4'h8: return 4'h7;
      4'h9: return 4'h8;
      4'ha: return 4'h9;
      4'h3: return 4'ha;
      4'hc: return 4'hb;
      4'hd: return 4'hc;
      default: return 4'h0;
    endcase
  endfunction

  logic [1:0] col_ff;
  logic [6:0] colcnt_ff;
  logic seen_ff, multi_ff, mdown_ff;
  lpd_code_t mcode_ff, seen_code_ff;
  logic [7:0] deb_ff;
  logic lock_ff;
  logic down;
  lpd_code_t raw;
  logic [3:0] idx1;
  logic [3:0] rows;

  // ****************************************
  // matrix scanning
  // ****************************************
  assign rows = ~key_input_line;
  // a full three-column cycle decides one matrix sample; two keys void it only when both fall in columns 0 and 1
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      col_ff <= 2'h0;
      colcnt_ff <= 7'h0;
      seen_ff <= 1'b0;
      multi_ff <= 1'b0;
      mdown_ff <= 1'b0;
      mcode_ff <= 4'h0;
      seen_code_ff <= 4'h0;
      scan_n_ff <= 3'h7;
    end else if (mode != LPD_M_MATRIX) begin
      scan_n_ff <= 3'h7;
      mdown_ff <= 1'b0;
      col_ff <= 2'h0;
    end else if (tick) begin
      if (colcnt_ff == 7'(COL_TK - 1)) begin
        colcnt_ff <= 7'h0;
        if (rows != 4'h0) begin
          if (seen_ff || (rows & (rows - 4'h1)) != 4'h0) multi_ff <= 1'b1;
          seen_ff <= 1'b1;
          seen_code_ff <= key_code(4'({row_of(rows), 2'h0}) - 4'(row_of(rows)) + 4'(col_ff));
        end
        if (col_ff == 2'h2) begin
          col_ff <= 2'h0;
          mdown_ff <= seen_ff | multi_ff | (rows != 4'h0);
          mcode_ff <= multi_ff ? 4'h0 : seen_code_ff;
          seen_ff <= 1'b0;
          multi_ff <= 1'b0;
          scan_n_ff <= 3'h6;
        end else begin
          col_ff <= col_ff + 2'h1;
          scan_n_ff <= ~(3'h1 << (col_ff + 2'h1));
        end
      end else begin
        colcnt_ff <= colcnt_ff + 7'h1;
      end
    end
  end

  // ****************************************
  // source select and anti-bounce
  // ****************************************
  // single-key: lowest pressed line wins
  always_comb begin
    idx1 = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (!keypad_n[i]) idx1 = 4'(i);
    end
    case (mode)
      LPD_M_SINGLE: begin
        down = ~&keypad_n;
        raw = key_code(idx1);
      end
      LPD_M_TWO7: begin
        down = key_common;
        raw = dec_two7(key_input_line);
      end
      LPD_M_BIN: begin
        down = key_common;
        raw = (key_input_line > 4'h0 && key_input_line < 4'hd) ? key_input_line : 4'h0;
      end
      default: begin
        down = mdown_ff;
        raw = mcode_ff;
      end
    endcase
  end

  // [R1] timer before data
  // [R2] accept after quiet period
  // the count restarts whenever the level drops out, so bounce never passes
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      deb_ff <= 8'h0;
      lock_ff <= 1'b0;
      acc_ff <= 1'b0;
      code_ff <= 4'h0;
    end else begin
      acc_ff <= 1'b0;
      if (down == lock_ff) begin
        deb_ff <= 8'h0;
      end else if (tick) begin
        if (deb_ff == 8'(DEB_TK - 1)) begin
          deb_ff <= 8'h0;
          lock_ff <= ~lock_ff;
          // [R15] unknown codes dropped
          if (!lock_ff && raw != 4'h0) begin
            acc_ff <= 1'b1;
            code_ff <= raw;
          end
        end else begin
          deb_ff <= deb_ff + 8'h1;
        end
      end
    end
  end

  AST_KEY_VALID: assert property (@(posedge clk) disable iff (!srst_n) // [R15]
    acc_ff |-> (code_ff != 4'h0 && code_ff < 4'hd))
    else $error("accepted key carries an unassigned code");
endmodule // lpd_keyin

// file: core/lpd_top.sv
// Purpose: loop-disconnect outdialling sequencer with APB control
// Assumes: pins asynchronous to clk, APB master on clk
// Notes: all dial timing counts ticks of an 18 kHz time base
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "lpd_map.svh"

// Notes on behaviour
// [R1] key press starts anti-bounce timer first
// [R2] accept after bounce; mute, pre-digit pause
// [R3] digit n lasts n times 100 ms
// [R4] gap of selected length between digits
// [R5] mute drops when last digit ends
// [R6] access pause stops dialling, drops mute
// [R7] hash during pause starts anti-bounce
// [R8] release key or inhibit low restarts
// [R9] after release, continue digits normally
// [R10] star stores pause, hash releases it
// [R11] hash otherwise redials the stored number
// [R12] gap select 700, 800, 900, test
// [R13] binary codes, 11 pause, 12 redial
// [R14] two-of-seven codes decoded per table
// [R15] unassigned codes are ignored
// [R16] all timings count clock ticks
// [R17] four break to make ratios
// [R18] four input formats selectable
// [R19] inhibit halts after digit or at once
// [R20] line transistor on only during break
// [R21] n pulses at 100 ms period
// [R22] digits dialled first in, first out
module lpd_top import lpd_pkg::*; #(
  parameter int TICK_DIV = `LPD_TICK_DIV,
  parameter int STORE_DEPTH = 22,
  parameter int DEB_TK = `LPD_DEB_TK
) (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [11:0] keypad_n,
  input logic [3:0] key_input_line,
  input logic key_common,
  input logic inhibit,
  output logic [2:0] scan_n,
  output logic line_out,
  output logic line_oe,
  output logic mute,
  output logic access_pause
);
  localparam int AW = $clog2(STORE_DEPTH + 1);

  // gap length in ticks minus one for each select value
  function automatic logic [14:0] gap_tk(input logic [1:0] sel);
    case (sel)
      2'h0: return 15'(`LPD_TK_MS(`LPD_GAP_A_MS) - 1);
      2'h1: return 15'(`LPD_TK_MS(`LPD_GAP_B_MS) - 1);
      2'h2: return 15'(`LPD_TK_MS(`LPD_GAP_C_MS) - 1);
      default: return 15'(`LPD_GAP_TEST_TK - 1);
    endcase
  endfunction
  // break share of one pulse period, in ticks
  function automatic logic [14:0] brk_tk(input logic [1:0] rsel, input logic test);
    int p;
    int n;
    p = test ? `LPD_TEST_PULSE_TK : `LPD_PULSE_TK;
    case (rsel)
      2'h0: n = `LPD_BRK_NUM_70;
      2'h1: n = `LPD_BRK_NUM_67;
      2'h2: n = `LPD_BRK_NUM_60;
      default: n = `LPD_BRK_NUM_50;
    endcase
    return 15'((p * n) / `LPD_RATIO_DEN);
  endfunction

  logic rst_s1_ff, rst_s2_ff, srst_n;
  logic [17:0] sync1_ff, sync2_ff;
  logic [13:0] div_ff;
  logic tick_ff;
  logic [5:0] ctrl_ff;
  logic clr_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  lpd_state_t state_ff;
  logic [14:0] tmr_ff;
  logic [3:0] pulses_ff;
  logic [AW-1:0] rd_ff, wr_ff;
  logic [3:0] mem_ff [STORE_DEPTH];
  logic mute_ff, ap_ff, aphold_ff, done_ff, line_oe_ff, inh_prev_ff;
  logic acc;
  lpd_code_t code;
  logic inh_s, inh_fall, tmr_done, k_dig, k_ap, k_hash, store_wr, test_sel;
  logic [1:0] ratio_sel, gap_sel;
  logic [AW-1:0] wr_idx;
  logic [14:0] brk_len, mak_len;

  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  // reset enters asynchronously, releases through two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign srst_n = rst_s2_ff;

  // two stages for every pin, only the second is read
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sync1_ff <= `LPD_SYNC_RST;
      sync2_ff <= `LPD_SYNC_RST;
    end else begin
      sync1_ff <= {inhibit, key_common, key_input_line, keypad_n};
      sync2_ff <= sync1_ff;
    end
  end
  assign inh_s = sync2_ff[17];

  // ****************************************
  // dialler time base
  // ****************************************
  // [R16] ticks from clock count
  // every dial timing below counts these ticks, so all scale together
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      div_ff <= 14'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 14'(TICK_DIV - 1));
      div_ff <= (div_ff == 14'(TICK_DIV - 1)) ? 14'h0 : div_ff + 14'h1;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // one wait state: answer is registered from the first access cycle
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        pslverr_ff <= paddr != `LPD_ADDR_CTRL && paddr != `LPD_ADDR_STAT;
        if (pwrite) prdata_ff <= 32'h0;
        else if (paddr == `LPD_ADDR_CTRL) prdata_ff <= {26'h0, ctrl_ff};
        else if (paddr == `LPD_ADDR_STAT) prdata_ff <= {16'h0, 5'(rd_ff), 5'(wr_ff),
            aphold_ff, ap_ff, mute_ff, state_ff};
        else prdata_ff <= 32'h0;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // control word; clear bit acts once and is not kept
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_ff <= `LPD_CTRL_RST;
      clr_ff <= 1'b0;
    end else begin
      clr_ff <= 1'b0;
      if (psel && penable && pready_ff && pwrite && paddr == `LPD_ADDR_CTRL) begin
        ctrl_ff <= pwdata[5:0];
        clr_ff <= pwdata[`LPD_CTRL_CLR_BIT];
      end
    end
  end
  // [R17] ratio select
  assign ratio_sel = ctrl_ff[`LPD_CTRL_RATIO_LSB +: 2];
  // [R12] gap select
  assign gap_sel = ctrl_ff[`LPD_CTRL_GAP_LSB +: 2];
  assign test_sel = gap_sel == 2'h3;
  assign brk_len = brk_tk(ratio_sel, test_sel);
  assign mak_len = 15'((test_sel ? `LPD_TEST_PULSE_TK : `LPD_PULSE_TK) - 1) - brk_len;

  // ****************************************
  // key input
  // ****************************************
  // [R18] format select
  lpd_keyin #(.DEB_TK(DEB_TK)) u_keyin (
    .clk(clk),
    .srst_n(srst_n),
    .tick(tick_ff),
    .mode(lpd_kmode_t'(ctrl_ff[`LPD_CTRL_MODE_LSB +: 2])),
    .keypad_n(sync2_ff[11:0]),
    .key_input_line(sync2_ff[15:12]),
    .key_common(sync2_ff[16]),
    .scan_n_ff(scan_n),
    .acc_ff(acc),
    .code_ff(code)
  );

  // [R10] star pauses, hash releases
  // [R13] pause and redial codes
  // [R14] decoded codes share meaning
  assign k_dig = acc && code > 4'h0 && code < 4'hb;
  assign k_ap = acc && code == 4'hb;
  assign k_hash = acc && code == 4'hc;
  // a key after a finished number starts a fresh one at slot zero
  assign store_wr = (k_dig || k_ap) && (done_ff || wr_ff != AW'(STORE_DEPTH));
  assign wr_idx = done_ff ? '0 : wr_ff;
  assign tmr_done = tick_ff && tmr_ff == 15'h0;
  assign inh_fall = inh_prev_ff && !inh_s;

  // digit store, flip-flops addressed by slot
  always_ff @(posedge clk) begin
    if (store_wr) mem_ff[wr_idx] <= code;
  end

  // ****************************************
  // outdialling sequencer
  // ****************************************
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_ff <= LPD_IDLE;
      tmr_ff <= 15'h0;
      pulses_ff <= 4'h0;
      rd_ff <= '0;
      wr_ff <= '0;
      mute_ff <= 1'b0;
      ap_ff <= 1'b0;
      aphold_ff <= 1'b0;
      done_ff <= 1'b0;
      line_oe_ff <= 1'b0;
      inh_prev_ff <= 1'b0;
    end else begin
      inh_prev_ff <= inh_s;
      if (tick_ff && tmr_ff != 15'h0) tmr_ff <= tmr_ff - 15'h1;
      if (store_wr) begin
        wr_ff <= done_ff ? AW'(1) : wr_ff + AW'(1);
        if (done_ff) rd_ff <= '0;
        done_ff <= 1'b0;
      end
      if (clr_ff) begin
        state_ff <= LPD_IDLE;
        rd_ff <= '0;
        wr_ff <= '0;
        done_ff <= 1'b0;
        mute_ff <= 1'b0;
        ap_ff <= 1'b0;
        line_oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          LPD_IDLE: begin
            // [R2] mute and pre-digit pause
            // [R11] hash replays the store
            if (store_wr || (k_hash && wr_ff != '0)) begin
              if (k_hash) rd_ff <= '0;
              done_ff <= 1'b0;
              mute_ff <= 1'b1;
              tmr_ff <= gap_tk(gap_sel);
              state_ff <= LPD_PRE;
            end
          end
          LPD_PRE, LPD_GAP: begin
            // [R19] inhibit in a pause halts at once
            if (inh_s) begin
              mute_ff <= 1'b0;
              aphold_ff <= 1'b0;
              state_ff <= LPD_HOLD;
            end else if (tmr_done && !store_wr) begin // a key landing now waits a tick
              if (rd_ff == wr_ff) begin
                mute_ff <= 1'b0;
                done_ff <= 1'b1;
                state_ff <= LPD_IDLE;
              end else if (mem_ff[rd_ff] == 4'hb) begin
                // [R6] stop and unmute at access pause
                rd_ff <= rd_ff + AW'(1);
                mute_ff <= 1'b0;
                ap_ff <= 1'b1;
                aphold_ff <= 1'b1;
                state_ff <= LPD_HOLD;
              end else begin
                // [R22] oldest digit first
                pulses_ff <= mem_ff[rd_ff];
                line_oe_ff <= 1'b1;
                tmr_ff <= brk_len - 15'h1;
                state_ff <= LPD_BRK;
              end
            end
          end
          LPD_BRK: begin
            // [R20] transistor off in make
            if (tmr_done) begin
              line_oe_ff <= 1'b0;
              tmr_ff <= mak_len;
              state_ff <= LPD_MAK;
            end
          end
          LPD_MAK: begin
            // [R3] [R21] n pulses of one period
            if (tmr_done) begin
              if (pulses_ff > 4'h1) begin
                pulses_ff <= pulses_ff - 4'h1;
                line_oe_ff <= 1'b1;
                tmr_ff <= brk_len - 15'h1;
                state_ff <= LPD_BRK;
              end else begin
                rd_ff <= rd_ff + AW'(1);
                if (rd_ff + AW'(1) == wr_ff && !store_wr) begin
                  // [R5] last digit ends mute
                  mute_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= LPD_IDLE;
                end else if (inh_s) begin
                  mute_ff <= 1'b0;
                  aphold_ff <= 1'b0;
                  state_ff <= LPD_HOLD;
                end else begin
                  // [R4] gap after each digit but the last
                  tmr_ff <= gap_tk(gap_sel);
                  state_ff <= LPD_GAP;
                end
              end
            end
          end
          default: begin
            // [R7] [R8] hash or inhibit low releases
            // [R9] resume with a pre-digit pause
            if (aphold_ff ? (k_hash || inh_fall) : !inh_s) begin
              mute_ff <= 1'b1;
              ap_ff <= 1'b0;
              aphold_ff <= 1'b0;
              tmr_ff <= gap_tk(gap_sel);
              state_ff <= LPD_PRE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // open drain: low level only, enable carries the break
  assign line_out = 1'b0;
  assign line_oe = line_oe_ff;
  assign mute = mute_ff;
  assign access_pause = ap_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************
  // checks
  // ****************************************
  AST_ACCEPT_MUTE: assert property (@(posedge clk) disable iff (!srst_n) // [R2]
    (state_ff == LPD_IDLE && k_dig && !clr_ff) |=> (mute_ff && state_ff == LPD_PRE))
    else $error("accepted digit did not start mute and pause");
  AST_GAP_LEN: assert property (@(posedge clk) disable iff (!srst_n) // [R4]
    (state_ff == LPD_GAP && $past(state_ff) == LPD_MAK)
    |-> tmr_ff == gap_tk(gap_sel))
    else $error("gap timer loaded with the wrong length");
  AST_LAST_UNMUTE: assert property (@(posedge clk) disable iff (!srst_n) // [R5]
    (state_ff == LPD_MAK && tmr_done && pulses_ff == 4'h1 && rd_ff + AW'(1) == wr_ff
     && !store_wr && !clr_ff) |=> (!mute_ff && state_ff == LPD_IDLE))
    else $error("mute held after the last digit");
  AST_HOLD_UNMUTED: assert property (@(posedge clk) disable iff (!srst_n) // [R6]
    state_ff == LPD_HOLD |-> !mute_ff)
    else $error("mute asserted while dialling is held");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!srst_n) // [R8]
    (state_ff == LPD_HOLD && aphold_ff && k_hash && !clr_ff)
    |=> (mute_ff && !access_pause && state_ff == LPD_PRE && tmr_ff == gap_tk(gap_sel)))
    else $error("release did not restart with a pre-digit pause");
  AST_INHIBIT_GAP: assert property (@(posedge clk) disable iff (!srst_n) // [R19]
    (state_ff inside {LPD_PRE, LPD_GAP} && inh_s && !clr_ff)
    |=> (state_ff == LPD_HOLD && !mute_ff))
    else $error("inhibit during a gap did not halt");
  AST_LINE_MAKE: assert property (@(posedge clk) disable iff (!srst_n) // [R20]
    state_ff inside {LPD_MAK, LPD_GAP, LPD_PRE, LPD_IDLE} |-> !line_oe_ff)
    else $error("line transistor on outside a break");
  AST_BRK_LEN: assert property (@(posedge clk) disable iff (!srst_n) // [R21]
    (state_ff != LPD_BRK ##1 state_ff == LPD_BRK) |-> tmr_ff == brk_len - 15'h1)
    else $error("break timer loaded with the wrong length");
  AST_FIFO_ORDER: assert property (@(posedge clk) disable iff (!srst_n) // [R22]
    ($past(state_ff) inside {LPD_PRE, LPD_GAP} && state_ff == LPD_BRK)
    |-> pulses_ff == mem_ff[$past(rd_ff)])
    else $error("digit taken out of order");
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!srst_n) // [R16]
    tick_ff |=> !tick_ff)
    else $error("time base ticks back to back");
endmodule // lpd_top

// file: sim/lpd_line_model.sv
// Purpose: line side model, turns break pulses back into digits
// Assumes: line_oe high means transistor on, i.e. a break
// Notes: a quiet line longer than GAP_CLK closes the current digit
`timescale 1ns/100ps
module lpd_line_model #(
  parameter int GAP_CLK = 160
) (
  input wire logic clk,
  input wire logic line_oe
);
  int cnt = 0;
  int quiet = 0;
  int bw = 0;
  int brk_clk = 0;
  int digits[$];
  logic oe_d = 1'b0;
  // ****************************************
  // pulse counting
  // ****************************************
  // count pulses per digit
  always @(posedge clk) begin
    oe_d <= line_oe;
    if (line_oe && !oe_d) begin
      cnt++;
      bw = 1;
      quiet = 0;
    end else if (line_oe) begin
      bw++;
    end else if (cnt > 0) begin
      if (oe_d) brk_clk = bw;
      quiet++;
      // make period is far below GAP_CLK, so only a real gap ends a digit
      if (quiet == GAP_CLK) begin
        digits.push_back(cnt);
        cnt = 0;
      end
    end
  end
endmodule // lpd_line_model

// file: sim/test_loop_pulse_dialler_sequencer.sv
// Purpose: self-checking bench of the dialler sequencer
// Assumes: binary code entry, test gap setting to keep runs short
// Notes: tick is 4 clocks, so one test pulse period is 120 clocks
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_loop_pulse_dialler_sequencer;
  import lpd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, key_common = 1'b0, line_oe, mute, access_pause;
  logic [3:0] key_input_line = 4'h0;
  logic [11:0] keypad_n = 12'hfff;
  logic [2:0] scan_n;
  logic line_out, mx = 1'b0, inhibit = 1'b0; // mx holds the matrix key at row 1, column 1 counted from zero (key 5)
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #2 clk = ~clk;
  lpd_top #(.TICK_DIV(4), .DEB_TK(3)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keypad_n(keypad_n),
    .key_input_line(key_input_line & {2'h3, scan_n[1] | !mx, 1'b1}),
    .key_common(key_common), .inhibit(inhibit), .scan_n(scan_n), .line_out(line_out),
    .line_oe(line_oe), .mute(mute), .access_pause(access_pause));
  lpd_line_model model (.clk(clk), .line_oe(line_oe));
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // bus, key and wait helpers
  // ****************************************
  // one idle cycle first so psel is never written twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic key(input logic [3:0] c);
    key_input_line <= c; key_common <= 1'b1;
    repeat (40) @(posedge clk);
    key_common <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic wait_on(input bit ap, input logic v);
    int n = 0;
    while ((ap ? access_pause : mute) !== v && n < 30000) begin @(posedge clk); n++; end
    repeat (200) @(posedge clk);
  endtask
  task automatic chk_dig(input int n, input int d0, input int d1, input int d2);
    `CHK(model.digits.size(), n)
    if (model.digits.size() == n && n == 3) `CHK({model.digits[0], model.digits[1],
      model.digits[2]}, {d0, d1, d2})
    if (model.digits.size() == n && n == 2) `CHK({model.digits[0], model.digits[1]}, {d0, d1})
    model.digits.delete();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    apb(1'b0, 8'h00, 0); `CHK(q, 32'h0)
    apb(1'b1, 8'h00, 32'h2c); apb(1'b0, 8'h00, 0); `CHK(q, 32'h2c)
    apb(1'b1, 8'h08, 32'h1); `CHK(e, 1'b1)
    apb(1'b0, 8'h08, 0); `CHK({e, q}, {1'b1, 32'h0})
    $display("regs done");
  endtask
  task automatic t_dial;
    key(4'h2); `CHK(mute, 1'b1)
    key(4'h1); key(4'ha);
    wait_on(1'b0, 1'b0); `CHK(mute, 1'b0)
    `CHK(model.brk_clk, 84)
    chk_dig(3, 2, 1, 10);
    key(4'hc); wait_on(1'b0, 1'b0);
    chk_dig(3, 2, 1, 10);
    apb(1'b0, 8'h04, 0); `CHK(q, 32'h18c0)
    $display("dial and redial done");
  endtask
  task automatic t_bad;
    key(4'hd); key(4'hf); key(4'h0);
    repeat (2000) @(posedge clk);
    `CHK(mute, 1'b0)
    chk_dig(0, 0, 0, 0);
    $display("bad codes done");
  endtask
  task automatic t_ap;
    key(4'h3); key(4'hb); key(4'h4);
    wait_on(1'b1, 1'b1); `CHK({access_pause, mute}, 2'b10)
    `CHK(model.digits.size(), 1)
    apb(1'b0, 8'h04, 0); `CHK(q, 32'h10f7)
    key(4'hc); `CHK({access_pause, mute}, 2'b01)
    wait_on(1'b0, 1'b0);
    chk_dig(2, 3, 4, 0);
    $display("access pause done");
  endtask
  task automatic t_inh;
    key(4'h5); key(4'h6); inhibit <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(mute, 1'b0)
    inhibit <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(mute, 1'b1)
    while (line_oe !== 1'b1) @(posedge clk);
    inhibit <= 1'b1;
    repeat (1200) @(posedge clk);
    `CHK({mute, model.digits.size()}, {1'b0, 32'd1})
    inhibit <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(mute, 1'b1)
    wait_on(1'b0, 1'b0);
    chk_dig(2, 5, 6, 0);
    apb(1'b1, 8'h00, 32'h6c); key(4'hc);
    `CHK(mute, 1'b0)
    $display("inhibit and clear done");
  endtask
  task automatic t_modes;
    apb(1'b1, 8'h00, 32'h1f); `CHK({line_out, scan_n}, 4'h7)
    key(4'h8); key(4'hc); wait_on(1'b0, 1'b0);
    `CHK(model.brk_clk, 60)
    chk_dig(2, 2, 10, 0);
    key_input_line <= 4'hf; apb(1'b1, 8'h00, 32'h0c);
    keypad_n <= 12'hfbf; repeat (40) @(posedge clk);
    keypad_n <= 12'hfff; apb(1'b1, 8'h00, 32'h3c);
    mx <= 1'b1; repeat (800) @(posedge clk);
    mx <= 1'b0; wait_on(1'b0, 1'b0);
    chk_dig(2, 7, 5, 0);
    $display("input modes done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_dial();
    t_bad();
    t_ap();
    t_inh();
    t_modes();
    tally_and_finish();
  end
endmodule // test_loop_pulse_dialler_sequencer
